/* File: common/sccf_pkg.sv */
package sccf_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] WTMR_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] NTA_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] NTB_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] IEN_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] STS_OFS = 8'h14;
	localparam logic [31:0] CTL_RST = 32'h0000_0000;
	localparam logic [31:0] TMR_RST = 32'h0000_0000;

	// ************************************************
	// control fields
	// ************************************************
	localparam int RTY_EN_B = 19;
	localparam int RTY_LIM_LSB = 16;
	localparam int RTY_LIM_W = 3;
	localparam int STOP_B = 15;
	localparam int TSEL_LSB = 13;
	localparam int BGT_LSB = 8;
	localparam int BGT_W = 5;
	localparam int THR_LSB = 6;
	localparam int CONV_LSB = 4;
	localparam int AUTO_B = 3;
	localparam int WIDE_W = 24;
	localparam int NARROW_W = 8;

	// status and enable bits
	localparam int STS_AVAIL_B = 0;
	localparam int STS_FAIL_B = 1;
	localparam int STS_TXH_B = 2;
	localparam int STS_RXH_B = 3;
	localparam int STS_CNT_LSB = 4;
	localparam int IEN_AVAIL_B = 0;

	localparam logic [1:0] TSEL_OFF = 2'h0;
	localparam logic [1:0] TSEL_WIDE = 2'h1;
	localparam logic [1:0] TSEL_ONE = 2'h2;
	localparam logic [1:0] CONV_DIRECT = 2'h0;
	localparam logic [1:0] CONV_INVERSE = 2'h3;
	localparam logic [1:0] THR_RSVD = 2'h3;

	typedef struct packed {
		logic rty_en;
		logic [RTY_LIM_W-1:0] rty_lim;
		logic stop_sel;
		logic [1:0] tsel;
		logic [BGT_W-1:0] block_guard_count;
		logic [1:0] thr;
		logic [1:0] conv;
		logic auto_en;
	} sccf_ctl_t;

	typedef struct packed {
		logic [2:0] en;
		logic [WIDE_W-1:0] wide;
		logic [NARROW_W-1:0] na;
		logic [NARROW_W-1:0] nb;
	} sccf_tmr_t;

	typedef enum logic [1:0] {
		RTY_IDLE = 2'b00,
		RTY_ACTIVE = 2'b01,
		RTY_EXHAUST = 2'b11
	} sccf_rty_t;

	function automatic sccf_ctl_t ctl_unpack(input logic [31:0] w);
		sccf_ctl_t c;
		c.rty_en = w[RTY_EN_B];
		c.rty_lim = w[RTY_LIM_LSB +: RTY_LIM_W];
		c.stop_sel = w[STOP_B];
		c.tsel = w[TSEL_LSB +: 2];
		c.block_guard_count = w[BGT_LSB +: BGT_W];
		c.thr = w[THR_LSB +: 2];
		c.conv = w[CONV_LSB +: 2];
		c.auto_en = w[AUTO_B];
		return c;
	endfunction

	function automatic logic [31:0] ctl_pack(input sccf_ctl_t c);
		logic [31:0] w;
		w = '0;
		w[RTY_EN_B] = c.rty_en;
		w[RTY_LIM_LSB +: RTY_LIM_W] = c.rty_lim;
		w[STOP_B] = c.stop_sel;
		w[TSEL_LSB +: 2] = c.tsel;
		w[BGT_LSB +: BGT_W] = c.block_guard_count;
		w[THR_LSB +: 2] = c.thr;
		w[CONV_LSB +: 2] = c.conv;
		w[AUTO_B] = c.auto_en;
		return w;
	endfunction

endpackage

/* File: hdl/sccf_guard.sv */
`timescale 1ns/1ps
module sccf_guard
	import sccf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic etu_tick_i,
	input wire logic tx_start_i,
	input wire logic rx_start_i,
	input wire logic [BGT_W-1:0] bgt_i,
	output logic tx_hold_o,
	output logic rx_hold_o
);
	localparam int CNT_W = BGT_W + 1;
	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] span;
	logic dir_tx_q;
	logic dir_tx_d;
	logic seen_q;
	logic seen_d;

	// ************************************************
	// bit lengths since last leading edge
	// ************************************************
	always_comb begin
		span = CNT_W'(bgt_i) + CNT_W'(1);
		cnt_d = cnt_q;
		dir_tx_d = dir_tx_q;
		seen_d = seen_q;
		if (tx_start_i || rx_start_i) begin
			cnt_d = '0;
			dir_tx_d = tx_start_i;
			seen_d = 1'b1;
		end else if (etu_tick_i && cnt_q != CNT_MAX) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			dir_tx_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			dir_tx_q <= dir_tx_d;
			seen_q <= seen_d;
		end
	end

	// RULE9 opposite direction spacing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_hold_o <= 1'b0;
			rx_hold_o <= 1'b0;
		end else begin
			tx_hold_o <= seen_d && !dir_tx_d && (cnt_d < span);
			rx_hold_o <= seen_d && dir_tx_d && (cnt_d < span);
		end
	end

endmodule

/* File: hdl/sccf_top.sv */
// Operation
// RULE1 - software sets retry limit before enabling retry
// RULE2 - parity retries allowed equal limit plus one
// RULE3 - retry limit frozen while retry enabled
// RULE4 - stop select 0 gives 2 ETU, 1 gives 1
// RULE5 - stop length defaults to 2 ETU
// RULE6 - timer select 00 off, 01 wide only
// RULE7 - timer select 10 adds first narrow timer
// RULE8 - timer select 11 runs all three timers
// RULE9 - guard spacing between directions is field plus one
// RULE10 - software loads guard 15 or 21
// RULE11 - avail flag when count equals threshold
// RULE12 - avail interrupt only when enabled
// RULE13 - convention code 00 is direct
// RULE14 - code 11 inverse, 01 and 10 reserved
// RULE15 - auto convention overrides software convention field
// RULE16 - retry enable bit turns on receive retries
`timescale 1ns/1ps
module sccf_top
	import sccf_pkg::*;
#(
	parameter int CNT_W = 3
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WE_I,
	input wire logic RE_I,
	output logic [31:0] RDATA_O,
	input wire logic PARITY_ERR_I,
	input wire logic RX_CHAR_OK_I,
	input wire logic ETU_TICK_I,
	input wire logic TX_START_I,
	input wire logic RX_START_I,
	input wire logic [CNT_W-1:0] RX_COUNT_I,
	input wire logic ACONV_DONE_I,
	input wire logic ACONV_INV_I,
	output logic RETRY_O,
	output logic RETRY_FAIL_O,
	output logic STOP_2ETU_O,
	output sccf_tmr_t TMR_O,
	output logic TX_HOLD_O,
	output logic RX_HOLD_O,
	output logic INVERSE_O,
	output logic RX_AVAIL_IRQ_O
);

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [2:0] tsel_en(input logic [1:0] s);
		case (s)
			TSEL_OFF: tsel_en = 3'h0;
			TSEL_WIDE: tsel_en = 3'h1;
			TSEL_ONE: tsel_en = 3'h3;
			default: tsel_en = 3'h7;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] thr_bytes(input logic [1:0] t);
		thr_bytes = CNT_W'(t) + CNT_W'(1);
	endfunction

	sccf_ctl_t ctl_q;
	sccf_ctl_t ctl_d;
	sccf_ctl_t wr_ctl;
	logic [WIDE_W-1:0] wtmr_q;
	logic [NARROW_W-1:0] nta_q;
	logic [NARROW_W-1:0] ntb_q;
	logic ien_q;
	logic avail_q;
	logic fail_flag_q;
	logic [3:0] rty_cnt_q;
	sccf_rty_t rty_q;
	logic avail_hit;
	logic ctl_we;
	logic sts_we;
	logic guard_tx;
	logic guard_rx;
	logic [2:0] tsel_bits;

	assign ctl_we = WE_I && (ADDR_I == CTL_OFS);
	assign sts_we = WE_I && (ADDR_I == STS_OFS);
	assign wr_ctl = ctl_unpack(WDATA_I);

	// ************************************************
	// control register
	// ************************************************
	always_comb begin
		ctl_d = ctl_q;
		if (ctl_we) begin
			ctl_d = wr_ctl;
			// RULE3 limit locked while enabled
			if (ctl_q.rty_en) begin
				ctl_d.rty_lim = ctl_q.rty_lim;
			end
			// RULE15 software convention ignored
			if (ctl_q.auto_en) begin
				ctl_d.conv = ctl_q.conv;
			end
		end
		// hardware detection beats a same-cycle write
		if (ACONV_DONE_I && ctl_q.auto_en) begin
			ctl_d.conv = ACONV_INV_I ? CONV_INVERSE : CONV_DIRECT;
		end
	end

	// RULE5 reset gives 2 ETU stop
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ctl_q <= ctl_unpack(CTL_RST);
		end else begin
			ctl_q <= ctl_d;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			wtmr_q <= TMR_RST[WIDE_W-1:0];
			nta_q <= TMR_RST[NARROW_W-1:0];
			ntb_q <= TMR_RST[NARROW_W-1:0];
			ien_q <= 1'b0;
		end else if (WE_I) begin
			if (ADDR_I == WTMR_OFS) begin
				wtmr_q <= WDATA_I[WIDE_W-1:0];
			end
			if (ADDR_I == NTA_OFS) begin
				nta_q <= WDATA_I[NARROW_W-1:0];
			end
			if (ADDR_I == NTB_OFS) begin
				ntb_q <= WDATA_I[NARROW_W-1:0];
			end
			if (ADDR_I == IEN_OFS) begin
				ien_q <= WDATA_I[IEN_AVAIL_B];
			end
		end
	end

	// ************************************************
	// receive retry
	// ************************************************
	// RULE1 limit taken as written
	// RULE2 limit plus one retries
	// RULE16 retry only when enabled
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			rty_q <= RTY_IDLE;
			rty_cnt_q <= '0;
			RETRY_O <= 1'b0;
			RETRY_FAIL_O <= 1'b0;
		end else begin
			RETRY_O <= 1'b0;
			RETRY_FAIL_O <= 1'b0;
			case (rty_q)
				RTY_IDLE, RTY_ACTIVE: begin
					if (!ctl_q.rty_en || RX_CHAR_OK_I) begin
						rty_q <= RTY_IDLE;
						rty_cnt_q <= '0;
					end else if (PARITY_ERR_I) begin
						if (rty_cnt_q < 4'(ctl_q.rty_lim) + 4'h1) begin
							rty_q <= RTY_ACTIVE;
							rty_cnt_q <= rty_cnt_q + 4'h1;
							RETRY_O <= 1'b1;
						end else begin
							rty_q <= RTY_EXHAUST;
							RETRY_FAIL_O <= 1'b1;
						end
					end
				end
				RTY_EXHAUST: begin
					if (!ctl_q.rty_en || RX_CHAR_OK_I) begin
						rty_q <= RTY_IDLE;
						rty_cnt_q <= '0;
					end
				end
				default: begin
					rty_q <= RTY_IDLE;
					rty_cnt_q <= '0;
				end
			endcase
		end
	end

	// sticky, write one clears, a new failure wins
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			fail_flag_q <= 1'b0;
		end else if (rty_q != RTY_EXHAUST && PARITY_ERR_I && ctl_q.rty_en
			&& !RX_CHAR_OK_I && rty_cnt_q >= 4'(ctl_q.rty_lim) + 4'h1) begin
			fail_flag_q <= 1'b1;
		end else if (sts_we && WDATA_I[STS_FAIL_B]) begin
			fail_flag_q <= 1'b0;
		end
	end

	// ************************************************
	// receive data available
	// ************************************************
	// RULE11 count meets threshold
	assign avail_hit = (ctl_q.thr != THR_RSVD) && (RX_COUNT_I == thr_bytes(ctl_q.thr));

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			avail_q <= 1'b0;
		end else if (avail_hit) begin
			avail_q <= 1'b1;
		end else if (sts_we && WDATA_I[STS_AVAIL_B]) begin
			avail_q <= 1'b0;
		end
	end

	// RULE12 gated interrupt
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			RX_AVAIL_IRQ_O <= 1'b0;
		end else begin
			RX_AVAIL_IRQ_O <= avail_q && ien_q;
		end
	end

	// ************************************************
	// character framing outputs
	// ************************************************
	sccf_guard u_guard (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.etu_tick_i(ETU_TICK_I),
		.tx_start_i(TX_START_I),
		.rx_start_i(RX_START_I),
		.bgt_i(ctl_q.block_guard_count),
		.tx_hold_o(guard_tx),
		.rx_hold_o(guard_rx)
	);
	assign TX_HOLD_O = guard_tx;
	assign RX_HOLD_O = guard_rx;

	// RULE4 stop length select
	// RULE13 direct on code 00
	// RULE14 reserved codes fall back to direct
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			STOP_2ETU_O <= 1'b1;
			INVERSE_O <= 1'b0;
		end else begin
			STOP_2ETU_O <= !ctl_q.stop_sel;
			INVERSE_O <= (ctl_q.conv == CONV_INVERSE);
		end
	end

	// ************************************************
	// timer selection
	// ************************************************
	// RULE6 off or wide only
	// RULE7 wide plus first narrow
	// RULE8 all three timers
	assign tsel_bits = tsel_en(ctl_q.tsel);

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			TMR_O <= '0;
		end else begin
			TMR_O.en <= tsel_bits;
			TMR_O.wide <= tsel_bits[0] ? wtmr_q : '0;
			TMR_O.na <= tsel_bits[1] ? nta_q : '0;
			TMR_O.nb <= tsel_bits[2] ? ntb_q : '0;
		end
	end

	// ************************************************
	// read port
	// ************************************************
	always_ff @(posedge CLK_I) begin
		if (RST_I || !RE_I) begin
			RDATA_O <= '0;
		end else begin
			case (ADDR_I)
				CTL_OFS: RDATA_O <= ctl_pack(ctl_q);
				WTMR_OFS: RDATA_O <= 32'(wtmr_q);
				NTA_OFS: RDATA_O <= 32'(nta_q);
				NTB_OFS: RDATA_O <= 32'(ntb_q);
				IEN_OFS: RDATA_O <= 32'(ien_q) << IEN_AVAIL_B;
				STS_OFS: begin
					RDATA_O <= (32'(avail_q) << STS_AVAIL_B)
						| (32'(fail_flag_q) << STS_FAIL_B)
						| (32'(guard_tx) << STS_TXH_B)
						| (32'(guard_rx) << STS_RXH_B)
						| (32'(rty_cnt_q) << STS_CNT_LSB);
				end
				default: RDATA_O <= '0;
			endcase
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	lim_frozen_a: assert property ($past(ctl_q.rty_en) |-> $stable(ctl_q.rty_lim)) // RULE3
		else $error("retry limit changed while enabled");

	rty_bound_a: assert property (rty_cnt_q <= 4'(ctl_q.rty_lim) + 4'h1 || $changed(ctl_q.rty_lim)) // RULE2
		else $error("retry count above limit");

	retry_cause_a: assert property (RETRY_O |-> $past(ctl_q.rty_en) && $past(PARITY_ERR_I)) // RULE16
		else $error("retry without enable and parity error");

	stop_len_a: assert property (##1 STOP_2ETU_O == !$past(ctl_q.stop_sel)) // RULE4
		else $error("stop length mismatch");

	timer_mode_a: assert property (##1 TMR_O.en == tsel_en($past(ctl_q.tsel))) // RULE6
		else $error("timer enables mismatch");

	ignored_cfg_a: assert property (ctl_q.tsel == TSEL_ONE // RULE7
		|=> TMR_O.nb == '0 && TMR_O.na == $past(nta_q))
		else $error("ignored timer control leaked");

	all_timers_a: assert property (&ctl_q.tsel |=> TMR_O.nb == $past(ntb_q)) // RULE8
		else $error("second narrow timer not configured");

	avail_set_a: assert property (avail_hit |=> avail_q) // RULE11
		else $error("avail flag not set");

	irq_gate_a: assert property (RX_AVAIL_IRQ_O |-> $past(ien_q) && $past(avail_q)) // RULE12
		else $error("interrupt without enable");

	auto_conv_a: assert property (ctl_q.auto_en && !ACONV_DONE_I |=> $stable(ctl_q.conv)) // RULE15
		else $error("convention changed while auto");

	conv_out_a: assert property (##1 INVERSE_O == ($past(ctl_q.conv) == CONV_INVERSE)) // RULE14
		else $error("convention output mismatch");

	guard_hold_a: assert property (RX_START_I && !TX_START_I |=> TX_HOLD_O) // RULE9
		else $error("no guard after receive start");

	retry_fail_c: cover property (RETRY_FAIL_O);
	auto_inv_c: cover property (ctl_q.auto_en && ACONV_DONE_I && ACONV_INV_I ##2 INVERSE_O);
	avail_irq_c: cover property (RX_AVAIL_IRQ_O);
	guard_c: cover property (TX_HOLD_O ##1 !TX_HOLD_O);

endmodule

/* File: testbench/sccf_card_model.sv */
`timescale 1ns/1ps
// ************************************************
// card side: bit clock and character events
// ************************************************
module sccf_card_model
	import sccf_pkg::*;
#(
	parameter int ETU_CYC = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic etu_tick_o,
	output logic parity_err_o,
	output logic char_ok_o,
	output logic tx_start_o,
	output logic rx_start_o,
	output logic aconv_done_o,
	output logic aconv_inv_o
);
	int etu_q;
	initial begin
		etu_q = 0;
		etu_tick_o = 1'b0;
		{parity_err_o, char_ok_o, tx_start_o, rx_start_o, aconv_done_o} = '0;
		aconv_inv_o = 1'b1;
	end
	// bit clock runs free, also between characters
	always @(posedge clk_i) begin
		etu_q <= (rst_i || etu_q == ETU_CYC - 1) ? 0 : etu_q + 1;
		etu_tick_o <= !rst_i && etu_q == ETU_CYC - 1;
	end
	// one event pulse; detect result only valid beside done
	task automatic pulse(input int k, input logic inv);
		@(posedge clk_i);
		case (k)
			0: parity_err_o <= 1'b1;
			1: char_ok_o <= 1'b1;
			2: tx_start_o <= 1'b1;
			3: rx_start_o <= 1'b1;
			default: aconv_done_o <= 1'b1;
		endcase
		aconv_inv_o <= inv;
		@(posedge clk_i);
		{parity_err_o, char_ok_o, tx_start_o, rx_start_o, aconv_done_o} <= '0;
		aconv_inv_o <= ~inv;
	endtask
endmodule

/* File: testbench/sccf_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module sccf_top_tb_top
	import sccf_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [2:0] rxcnt = '0;
	logic [31:0] rdata;
	logic retry, fail, stop2, txh, rxh, inv, irq;
	sccf_tmr_t tmr;
	logic etu, perr, cok, txs, rxs, adone, ainv;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] r = 32'hbd16;
	logic [31:0] tv [3];

	always #5 clk = ~clk;

	sccf_card_model #(.ETU_CYC(4)) card (.clk_i(clk), .rst_i(rst), .etu_tick_o(etu),
		.parity_err_o(perr), .char_ok_o(cok), .tx_start_o(txs), .rx_start_o(rxs),
		.aconv_done_o(adone), .aconv_inv_o(ainv));

	sccf_top #(.CNT_W(3)) dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WE_I(we), .RE_I(re), .RDATA_O(rdata), .PARITY_ERR_I(perr), .RX_CHAR_OK_I(cok),
		.ETU_TICK_I(etu), .TX_START_I(txs), .RX_START_I(rxs), .RX_COUNT_I(rxcnt),
		.ACONV_DONE_I(adone), .ACONV_INV_I(ainv), .RETRY_O(retry), .RETRY_FAIL_O(fail),
		.STOP_2ETU_O(stop2), .TMR_O(tmr), .TX_HOLD_O(txh), .RX_HOLD_O(rxh),
		.INVERSE_O(inv), .RX_AVAIL_IRQ_O(irq));

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [2:0] exp_en(input logic [1:0] s);
		return (s == 2'h0) ? 3'h0 : (s == 2'h1) ? 3'h1 : (s == 2'h2) ? 3'h3 : 3'h7;
	endfunction
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ticks counted while the opposite direction is held off
	task automatic guard(input logic [4:0] g, input int k, output int n);
		int c;
		wr(CTL_OFS, 32'(g) << BGT_LSB);
		card.pulse(k, 1'b0);
		n = 0;
		for (c = 0; c < 400; c++) begin
			#1;
			if ((k == 2 ? rxh : txh) !== 1'b1)
				break;
			if (etu === 1'b1)
				n++;
			@(posedge clk);
		end
	endtask
	task automatic retry_run(input logic [2:0] lim);
		int i;
		logic [31:0] d;
		// limit goes in before the enable, as software must
		wr(CTL_OFS, 32'(lim) << RTY_LIM_LSB);
		wr(CTL_OFS, (32'(lim) << RTY_LIM_LSB) | (32'h1 << RTY_EN_B));
		for (i = 0; i <= lim + 1; i++) begin
			card.pulse(0, 1'b0);
			#1;
			`CHK(retry, i <= lim)
			`CHK(fail, i > lim)
		end
		rd(STS_OFS, d);
		`CHK(d[STS_FAIL_B], 1'b1)
		`CHK(d[STS_CNT_LSB +: 4], 4'(lim) + 4'h1)
		wr(STS_OFS, 32'h1 << STS_FAIL_B);
		rd(STS_OFS, d);
		`CHK(d[STS_FAIL_B], 1'b0)
		wr(CTL_OFS, (32'(~lim) << RTY_LIM_LSB) | (32'h1 << RTY_EN_B));
		rd(CTL_OFS, d);
		`CHK(d[RTY_LIM_LSB +: 3], lim)
		card.pulse(1, 1'b0);
		card.pulse(0, 1'b0);
		#1;
		`CHK(retry, 1'b1)
		wr(CTL_OFS, 32'h0);
		card.pulse(0, 1'b0);
		#1;
		`CHK(retry, 1'b0)
		wr(CTL_OFS, 32'(~lim) << RTY_LIM_LSB);
		rd(CTL_OFS, d);
		`CHK(d[RTY_LIM_LSB +: 3], ~lim)
	endtask

	// ************************************************
	// hang guard
	// ************************************************
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		int i;
		int n;
		logic [31:0] d;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		`CHK(stop2, 1'b1)
		`CHK(tmr, '0)
		rd(CTL_OFS, d);
		`CHK(d, CTL_RST)
		rd(8'h3c, d);
		`CHK(d, 32'h0)
		wr(CTL_OFS, 32'h1 << STOP_B);
		wt(1);
		`CHK(stop2, 1'b0)
		wr(CTL_OFS, 32'h0);
		wt(1);
		`CHK(stop2, 1'b1)
		for (i = 0; i < 3; i++) begin
			r = nxt(r);
			tv[i] = r;
		end
		wr(WTMR_OFS, tv[0]);
		wr(NTA_OFS, tv[1]);
		wr(NTB_OFS, tv[2]);
		for (i = 0; i < 4; i++) begin
			wr(CTL_OFS, 32'(i) << TSEL_LSB);
			wt(1);
			`CHK(tmr.en, exp_en(2'(i)))
			`CHK(tmr.wide, i > 0 ? tv[0][23:0] : 24'h0)
			`CHK(tmr.na, i > 1 ? tv[1][7:0] : 8'h0)
			`CHK(tmr.nb, i > 2 ? tv[2][7:0] : 8'h0)
		end
		r = nxt(r);
		retry_run(r[2:0]);
		retry_run(3'h7);
		// guard counts loaded as the card protocols demand
		guard(5'd15, 2, n);
		`CHK(n, 16)
		guard(5'd21, 3, n);
		`CHK(n, 22)
		for (i = 0; i < 4; i++) begin
			wr(IEN_OFS, {31'h0, i != 2});
			wr(CTL_OFS, 32'(i) << THR_LSB);
			rxcnt <= 3'(i + 1);
			wt(3);
			`CHK(irq, i < 2)
			rd(STS_OFS, d);
			`CHK(d[STS_AVAIL_B], i != 3)
			rxcnt <= 3'h0;
			wr(STS_OFS, 32'h1 << STS_AVAIL_B);
			wt(2);
			`CHK(irq, 1'b0)
		end
		for (i = 0; i < 4; i++) begin
			wr(CTL_OFS, 32'(i) << CONV_LSB);
			wt(1);
			`CHK(inv, i == 3)
		end
		wr(CTL_OFS, 32'h1 << AUTO_B);
		wr(CTL_OFS, (32'h1 << AUTO_B) | (32'h3 << CONV_LSB));
		wt(1);
		`CHK(inv, 1'b0)
		card.pulse(5, 1'b1);
		wt(1);
		`CHK(inv, 1'b1)
		complete_run();
	end
endmodule
